// file: core/ppcdr_pad.sv
// Purpose: direction, drive type and slew of one 8-pin port
// Assumes: pin inputs asynchronous to mclk
// Notes: oe low while the pin is driven
`timescale 1ns/1ns
module ppcdr_pad import ppcdr_pkg::*; (
  input wire logic mclk,
  input wire logic srst,
  ppcdr_pin_if.pad bus
);
  typedef struct packed {
    logic [7:0] meta;
    logic [7:0] level;
    logic [7:0] driving;
    logic [7:0] pinOut;
    logic [7:0] pinOe_n;
    logic [7:0] slewFast;
  } ppcdr_pad_state_t;

  ppcdr_pad_state_t s_q;
  ppcdr_pad_state_t s_d;
  logic [7:0] drive;

  always_comb begin
    s_d = s_q;
    drive = bus.dir | bus.oeTerm;
    s_d.meta = bus.pinIn;
    s_d.level = s_q.meta;
    s_d.driving = drive;
    s_d.pinOut = bus.dOut;
    s_d.pinOe_n = ~(drive & ~(bus.odSel & bus.dOut));
    s_d.slewFast = bus.slewSel;
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      s_q <= '0;
      s_q.pinOe_n <= ALL_PINS;
    end else begin
      s_q <= s_d;
    end
  end

  assign bus.level = s_q.level;
  assign bus.driving = s_q.driving;
  assign bus.pinOut = s_q.pinOut;
  assign bus.pinOe_n = s_q.pinOe_n;
  assign bus.slewFast = s_q.slewFast;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  sequence cmosDrive;
    (bus.dir[0] | bus.oeTerm[0]) && !bus.odSel[0];
  endsequence

  AST_PAD_DIR: assert property (##1 s_q.driving == $past(bus.dir | bus.oeTerm))
    else $error("pin direction not dir or enable term");
  AST_PAD_CMOS: assert property (cmosDrive |=> !s_q.pinOe_n[0])
    else $error("push-pull pin not driven");
  AST_PAD_OD: assert property (bus.odSel[0] && bus.dOut[0] |=> s_q.pinOe_n[0])
    else $error("open-drain pin drove a high");
  AST_PAD_SLEW: assert property (bus.slewSel[0] |=> s_q.slewFast[0])
    else $error("fast slew not selected");
endmodule : ppcdr_pad

// file: core/ppcdr_port_regs.sv
// Purpose: per-port configuration and data registers of four ports
// Assumes: host register port on mclk, read data one cycle after hostRd
// Notes: port D has three pins; ports A-C carry the cell registers
`timescale 1ns/1ns
module ppcdr_port_regs import ppcdr_pkg::*; (
  input wire logic mclk,
  input wire logic srst,
  input wire logic [5:0] hostAddr,
  input wire logic hostWr,
  input wire logic hostRd,
  input wire logic [7:0] hostWdata,
  output logic [7:0] hostRdata,
  input wire logic [31:0] portPinIn,
  output logic [31:0] portPinOut,
  output logic [31:0] portPinOe_n,
  output logic [31:0] portSlewFast,
  input wire logic [31:0] pldOe,
  input wire logic [31:0] pldOutSel,
  input wire logic [7:0] cellNextFirst,
  input wire logic [7:0] cellNextSecond,
  input wire logic firstToB,
  input wire logic secondToC,
  input wire logic [15:0] addrOutValue,
  input wire logic [2:0] externalSelectTerm,
  input wire logic [2:0] externalSelectPolarity,
  input wire logic busModeA,
  input wire logic busDriveA,
  input wire logic [7:0] busDataA,
  input wire logic [2:0] fourthPortDedicated,
  input wire logic dbeMode,
  input wire logic batteryMode,
  input wire logic vccBelowBat,
  output logic [23:0] logicInputCells,
  output logic [2:0] fourthPortArray,
  output logic [7:0] outputCellGroupFirst,
  output logic [7:0] outputCellGroupSecond,
  output logic dataByteEnableIn,
  output logic batteryOnIndicator,
  output logic ioSpaceDisabled
);
  typedef struct packed {
    logic [3:0][7:0] dir;
    logic [3:0][7:0] drv;
    logic [3:0][7:0] dout;
    logic [1:0][7:0] ctrl;
    logic [2:0][7:0] mask;
    logic [2:0][7:0] cellIn;
    logic [7:0] cellFirst;
    logic [7:0] cellSecond;
    logic strobePrev;
    logic clockPrev;
    logic vccMeta;
    logic vccSync;
    logic [7:0] rdata;
    logic byteEnable;
    logic batteryOn;
    logic selectOff;
  } ppcdr_regs_state_t;

  ppcdr_regs_state_t s_q;
  ppcdr_regs_state_t s_d;
  logic [3:0][7:0] pinLevel;
  logic [3:0][7:0] pinDriving;
  logic [3:0][7:0] padDir;
  logic [3:0][7:0] padOe;
  logic [3:0][7:0] padData;
  logic [3:0][7:0] padOd;
  logic [3:0][7:0] padSlew;
  logic [3:0][7:0] forceIn;
  logic [1:0] hostPort;
  logic [3:0] hostReg;
  logic access;
  logic strobeRise;
  logic cellTick;
  logic [1:0] cellHitNow;
  logic [7:0] externalSelectOutputs;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // cell outputs as seen at a port
  function automatic logic [7:0] cellView(input logic [1:0] p, input logic [7:0] first,
      input logic [7:0] second, input logic toB, input logic toC, input logic [7:0] ecs);
    case (p)
      PORT_A: cellView = toB ? RESET_BYTE : first;
      PORT_B: cellView = toB ? first : (toC ? RESET_BYTE : second);
      PORT_C: cellView = toC ? second : RESET_BYTE;
      default: cellView = ecs;
    endcase
  endfunction : cellView

  // which group a host write at this port loads: {second, first}
  function automatic logic [1:0] cellHit(input logic [1:0] p, input logic toB,
      input logic toC);
    case (p)
      PORT_A: cellHit = {1'b0, !toB};
      PORT_B: cellHit = {!toB && !toC, toB};
      PORT_C: cellHit = {toC, 1'b0};
      default: cellHit = 2'h0;
    endcase
  endfunction : cellHit

  // ----------------------------------------------------------------
  // pad instances
  // ----------------------------------------------------------------
  ppcdr_pin_if pif[4] ();

  for (genvar g = 0; g < 4; g++) begin : gPort
    assign pif[g].dir = padDir[g];
    assign pif[g].oeTerm = padOe[g];
    assign pif[g].dOut = padData[g];
    assign pif[g].odSel = padOd[g];
    assign pif[g].slewSel = padSlew[g];
    assign pif[g].pinIn = portPinIn[g*8 +: 8];
    assign pinLevel[g] = pif[g].level;
    assign pinDriving[g] = pif[g].driving;
    assign portPinOut[g*8 +: 8] = pif[g].pinOut;
    assign portPinOe_n[g*8 +: 8] = pif[g].pinOe_n;
    assign portSlewFast[g*8 +: 8] = pif[g].slewFast;
    ppcdr_pad uPad (
      .mclk(mclk),
      .srst(srst),
      .bus(pif[g].pad)
    );
  end

  // ----------------------------------------------------------------
  // pin drive selection
  // ----------------------------------------------------------------
  always_comb begin
    externalSelectOutputs = {5'h00, externalSelectTerm ^ externalSelectPolarity};
    forceIn = '0;
    forceIn[PORT_C][C_STANDBY_BIT] = batteryMode;
    forceIn[PORT_C][C_BYTE_EN_BIT] = dbeMode;
    forceIn[PORT_D][2:0] = fourthPortDedicated;
    for (int p = 0; p < 4; p++) begin
      logic [7:0] ok;
      logic [7:0] base;
      logic [7:0] cells;
      ok = pinMask(2'(p)) & ~forceIn[p];
      cells = cellView(2'(p), s_q.cellFirst, s_q.cellSecond, firstToB, secondToC,
        externalSelectOutputs);
      base = s_q.dout[p];
      if (p < 2) begin
        base = (s_q.ctrl[p[0]] & addrOutValue[p[0]*PORT_W +: PORT_W]) |
          (~s_q.ctrl[p[0]] & s_q.dout[p]);
      end
      padDir[p] = s_q.dir[p] & ok;
      padOe[p] = pldOe[p*8 +: 8] & ok;
      padData[p] = (pldOutSel[p*8 +: 8] & cells) | (~pldOutSel[p*8 +: 8] & base);
      padOd[p] = s_q.drv[p] & odMask(2'(p));
      padSlew[p] = s_q.drv[p] & slewMask(2'(p));
    end
    if (busModeA) begin
      padDir[PORT_A] = RESET_BYTE;
      padOe[PORT_A] = {8{busDriveA}};
      padData[PORT_A] = busDataA;
    end
    if (batteryMode) begin
      padDir[PORT_C][C_BATTERY_BIT] = 1'b1;
      padData[PORT_C][C_BATTERY_BIT] = s_q.batteryOn;
    end
  end

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    hostPort = hostAddr[5:4];
    hostReg = hostAddr[3:0];
    cellHitNow = cellHit(hostPort, firstToB, secondToC);
    access = !s_q.selectOff;
    strobeRise = fourthPortDedicated[D_STROBE_BIT] && pinLevel[PORT_D][D_STROBE_BIT] &&
      !s_q.strobePrev;
    cellTick = fourthPortDedicated[D_CLOCK_BIT] ?
      (pinLevel[PORT_D][D_CLOCK_BIT] && !s_q.clockPrev) : 1'b1;
    s_d.strobePrev = pinLevel[PORT_D][D_STROBE_BIT];
    s_d.clockPrev = pinLevel[PORT_D][D_CLOCK_BIT];
    s_d.selectOff = fourthPortDedicated[D_SELECT_BIT] && pinLevel[PORT_D][D_SELECT_BIT];
    s_d.vccMeta = vccBelowBat;
    s_d.vccSync = s_q.vccMeta;
    s_d.batteryOn = batteryMode && s_q.vccSync;
    s_d.byteEnable = dbeMode && pinLevel[PORT_C][C_BYTE_EN_BIT];
    // input cells: held by the strobe, else follow the pins
    for (int p = 0; p < 3; p++) begin
      if (!fourthPortDedicated[D_STROBE_BIT] || strobeRise) begin
        s_d.cellIn[p] = pinLevel[p];
      end
    end
    if (cellTick) begin
      s_d.cellFirst = cellNextFirst;
      s_d.cellSecond = cellNextSecond;
    end
    // host write
    if (hostWr && access) begin
      case (hostReg)
        REG_DATA_OUT: s_d.dout[hostPort] = hostWdata & pinMask(hostPort);
        REG_DIR: s_d.dir[hostPort] = hostWdata & pinMask(hostPort);
        REG_DRIVE: begin
          s_d.drv[hostPort] = hostWdata & (odMask(hostPort) | slewMask(hostPort));
        end
        REG_CTRL: begin
          if (hostPort < PORT_C) begin
            s_d.ctrl[hostPort[0]] = hostWdata;
          end
        end
        REG_CELL_MASK: begin
          if (hostPort != PORT_D) begin
            s_d.mask[hostPort] = hostWdata;
          end
        end
        REG_CELL_OUT: begin
          if (hostPort != PORT_D) begin
            if (cellHitNow[0]) begin
              s_d.cellFirst = (s_d.cellFirst & s_q.mask[hostPort]) |
                (hostWdata & ~s_q.mask[hostPort]);
            end
            if (cellHitNow[1]) begin
              s_d.cellSecond = (s_d.cellSecond & s_q.mask[hostPort]) |
                (hostWdata & ~s_q.mask[hostPort]);
            end
          end
        end
        default: begin
        end
      endcase
    end
    // host read, answered on the next edge
    s_d.rdata = RESET_BYTE;
    if (hostRd && access) begin
      case (hostReg)
        REG_DATA_IN: s_d.rdata = pinLevel[hostPort] & pinMask(hostPort);
        REG_DATA_OUT: s_d.rdata = s_q.dout[hostPort];
        REG_DIR: s_d.rdata = s_q.dir[hostPort];
        REG_DRIVE: s_d.rdata = s_q.drv[hostPort];
        REG_CTRL: s_d.rdata = (hostPort < PORT_C) ? s_q.ctrl[hostPort[0]] : RESET_BYTE;
        REG_CELL_OUT: begin
          s_d.rdata = (hostPort == PORT_D) ? RESET_BYTE : cellView(hostPort, s_q.cellFirst,
            s_q.cellSecond, firstToB, secondToC, RESET_BYTE);
        end
        REG_CELL_MASK: begin
          s_d.rdata = (hostPort == PORT_D) ? RESET_BYTE : s_q.mask[hostPort];
        end
        REG_CELL_IN: begin
          s_d.rdata = (hostPort == PORT_D) ? RESET_BYTE : s_q.cellIn[hostPort];
        end
        REG_ENABLE_OUT: begin
          s_d.rdata = (hostPort == PORT_D) ? RESET_BYTE : pinDriving[hostPort];
        end
        default: s_d.rdata = RESET_BYTE;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign hostRdata = s_q.rdata;
  assign logicInputCells = {s_q.cellIn[2], s_q.cellIn[1], s_q.cellIn[0]};
  assign fourthPortArray = pinLevel[PORT_D][2:0];
  assign outputCellGroupFirst = s_q.cellFirst;
  assign outputCellGroupSecond = s_q.cellSecond;
  assign dataByteEnableIn = s_q.byteEnable;
  assign batteryOnIndicator = s_q.batteryOn;
  assign ioSpaceDisabled = s_q.selectOff;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  sequence readAt(logic [1:0] p, logic [3:0] r);
    hostRd && access && hostPort == p && hostReg == r;
  endsequence

  sequence writeAt(logic [1:0] p, logic [3:0] r);
    hostWr && access && hostPort == p && hostReg == r;
  endsequence

  AST_DIN_READ: assert property (readAt(PORT_A, REG_DATA_IN) |=>
    hostRdata == $past(pinLevel[PORT_A]))
    else $error("data-in read not the pin level");
  AST_DOUT_READBACK: assert property (writeAt(PORT_B, REG_DATA_OUT) ##1 !hostWr ##1
    readAt(PORT_B, REG_DATA_OUT) ##0 !hostWr |=> hostRdata == $past(hostWdata, 3))
    else $error("data-out readback mismatch");
  AST_MASK_BLOCK: assert property (writeAt(PORT_A, REG_CELL_OUT) ##0 (!firstToB &&
    s_q.mask[PORT_A] == ALL_PINS && !cellTick) |=> $stable(s_q.cellFirst))
    else $error("masked cell was loaded");
  AST_CELL_LOAD: assert property (writeAt(PORT_A, REG_CELL_OUT) ##0 (!firstToB &&
    s_q.mask[PORT_A] == RESET_BYTE) |=> s_q.cellFirst == $past(hostWdata))
    else $error("unmasked cell not loaded");
  AST_RESET_CLEAR: assert property ($fell(srst) |-> s_q.dir == '0 &&
    s_q.drv == '0 && s_q.ctrl == '0 && s_q.mask == '0)
    else $error("configuration not cleared by reset");
  AST_D_UPPER: assert property (s_q.drv[PORT_D][7:3] == 5'h00)
    else $error("port D upper drive bits set");
  AST_ENOUT: assert property (readAt(PORT_B, REG_ENABLE_OUT) |=>
    hostRdata == $past(pinDriving[PORT_B]))
    else $error("enable readback mismatch");
  AST_SELECT_OFF: assert property (s_q.selectOff && hostRd |=> hostRdata == RESET_BYTE)
    else $error("register space answered while deselected");
  AST_DRIVE_SPLIT: assert property (padOd[PORT_A][3:0] == 4'h0 &&
    padSlew[PORT_A][7:4] == 4'h0)
    else $error("port A drive bits mixed up");
  AST_C_NO_SLEW: assert property (padSlew[PORT_C] == RESET_BYTE)
    else $error("port C slew selected");
  AST_D_NO_OD: assert property (padOd[PORT_D] == RESET_BYTE)
    else $error("port D open drain selected");
  AST_DIR_D_UPPER: assert property (s_q.dir[PORT_D][7:3] == 5'h00)
    else $error("port D upper direction bits set");
  AST_CTRL_C: assert property (readAt(PORT_C, REG_CTRL) |=> hostRdata == RESET_BYTE)
    else $error("port C control register answered");
  AST_D_ABSENT: assert property (readAt(PORT_D, REG_CELL_MASK) |=>
    hostRdata == RESET_BYTE)
    else $error("port D mask register answered");
  AST_SEL_POL: assert property (pldOutSel[PORT_D * PORT_W] |-> padData[PORT_D][0] ==
    (externalSelectTerm[0] ^ externalSelectPolarity[0]))
    else $error("select output polarity wrong");
  AST_BUS_A: assert property (busModeA |-> padDir[PORT_A] == RESET_BYTE &&
    padData[PORT_A] == busDataA)
    else $error("port A not following the host data bus");
  AST_ADDR_OUT: assert property (s_q.ctrl[PORT_A][0] && !pldOutSel[0] && !busModeA |->
    padData[PORT_A][0] == addrOutValue[0])
    else $error("address bit not on port A");
  AST_SELECT_IN: assert property (fourthPortDedicated[D_SELECT_BIT] |->
    !padDir[PORT_D][D_SELECT_BIT] && !padOe[PORT_D][D_SELECT_BIT])
    else $error("chip select pin driven");
  AST_BATT_PIN: assert property (batteryMode |-> padDir[PORT_C][C_BATTERY_BIT] &&
    padData[PORT_C][C_BATTERY_BIT] == s_q.batteryOn)
    else $error("battery indicator pin not driven");
  AST_BYTE_EN: assert property (dbeMode |-> !padDir[PORT_C][C_BYTE_EN_BIT] &&
    !padOe[PORT_C][C_BYTE_EN_BIT])
    else $error("byte enable pin driven");
endmodule : ppcdr_port_regs

// file: include/ppcdr_pin_if.sv
// Purpose: carrier between register core and one port's pad logic
// Assumes: one instance per port
// Notes: pad outputs are registered in the pad module
`timescale 1ns/1ns
interface ppcdr_pin_if;
  logic [7:0] dir;
  logic [7:0] oeTerm;
  logic [7:0] dOut;
  logic [7:0] odSel;
  logic [7:0] slewSel;
  logic [7:0] pinIn;
  logic [7:0] level;
  logic [7:0] driving;
  logic [7:0] pinOut;
  logic [7:0] pinOe_n;
  logic [7:0] slewFast;
  modport core (output dir, oeTerm, dOut, odSel, slewSel, pinIn,
    input level, driving, pinOut, pinOe_n, slewFast);
  modport pad (input dir, oeTerm, dOut, odSel, slewSel, pinIn,
    output level, driving, pinOut, pinOe_n, slewFast);
endinterface : ppcdr_pin_if

// file: include/ppcdr_pkg.sv
// Purpose: constants for the port pin configuration and data registers
// Assumes: one 8-bit host register port, register index in hostAddr[3:0]
// Notes: host port number in hostAddr[5:4]
// Summary of operation
// - pin drives when direction or enable term set
// - drive bit one selects open drain
// - drive bit one selects fast slew
// - ports A,B: bits 7-4 drain, 3-0 slew
// - port C: all eight bits open drain
// - port D: three pins, bits 2-0 slew
// - data-in read returns sampled pin levels
// - data-out stored, driven when enabled, readable
// - cell location reads cells, loads unmasked bits
// - mask bit one blocks cell loading, resets zero
// - input cells capture pins, feed array, readable
// - enable readback shows one while driving
// - cell, mask, enable registers only ports A-C
// - port C: no control, pin seven byte enable
// - port D pins: strobe, cell clock, chip select
// - port D: three selectable-polarity select outputs
// - port D pins feed array directly
// - cell groups routable A/B and B/C
// - only port A carries host data bus
// - port C pin two standby, pin four battery
// - control bit zero I/O, one address out
// - control, direction, drive reset to zero
package ppcdr_pkg;
  localparam int PORT_W = 8;
  localparam logic [1:0] PORT_A = 2'h0;
  localparam logic [1:0] PORT_B = 2'h1;
  localparam logic [1:0] PORT_C = 2'h2;
  localparam logic [1:0] PORT_D = 2'h3;
  localparam logic [3:0] REG_DATA_IN = 4'h0;
  localparam logic [3:0] REG_DATA_OUT = 4'h1;
  localparam logic [3:0] REG_DIR = 4'h2;
  localparam logic [3:0] REG_DRIVE = 4'h3;
  localparam logic [3:0] REG_CTRL = 4'h4;
  localparam logic [3:0] REG_CELL_OUT = 4'h5;
  localparam logic [3:0] REG_CELL_MASK = 4'h6;
  localparam logic [3:0] REG_CELL_IN = 4'h7;
  localparam logic [3:0] REG_ENABLE_OUT = 4'h8;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] ALL_PINS = 8'hFF;
  localparam logic [7:0] FOURTH_PINS = 8'h07;
  localparam logic [7:0] OD_AB = 8'hF0;
  localparam logic [7:0] SLEW_AB = 8'h0F;
  localparam logic [7:0] OD_C = 8'hFF;
  localparam logic [7:0] SLEW_D = 8'h07;
  localparam int C_STANDBY_BIT = 2;
  localparam int C_BATTERY_BIT = 4;
  localparam int C_BYTE_EN_BIT = 7;
  localparam int D_STROBE_BIT = 0;
  localparam int D_CLOCK_BIT = 1;
  localparam int D_SELECT_BIT = 2;

  function automatic logic [7:0] pinMask(input logic [1:0] p);
    pinMask = (p == PORT_D) ? FOURTH_PINS : ALL_PINS;
  endfunction : pinMask

  function automatic logic [7:0] odMask(input logic [1:0] p);
    case (p)
      PORT_A, PORT_B: odMask = OD_AB;
      PORT_C: odMask = OD_C;
      default: odMask = RESET_BYTE;
    endcase
  endfunction : odMask

  function automatic logic [7:0] slewMask(input logic [1:0] p);
    case (p)
      PORT_A, PORT_B: slewMask = SLEW_AB;
      PORT_D: slewMask = SLEW_D;
      default: slewMask = RESET_BYTE;
    endcase
  endfunction : slewMask
endpackage : ppcdr_pkg

// file: tb/ppcdr_pin_model.sv
// Purpose: far-side pins of the four ports with board pull-ups
// Assumes: a released pin floats high unless the bench drives it
// Notes: the block wins where both sides drive
`timescale 1ns/1ns
module ppcdr_pin_model (
  input wire logic [31:0] pinOut,
  input wire logic [31:0] pinOe_n,
  input wire logic [31:0] extVal,
  input wire logic [31:0] extEn,
  output logic [31:0] pinIn
);
  always_comb begin
    for (int b = 0; b < 32; b++) begin
      if (!pinOe_n[b]) begin
        pinIn[b] = pinOut[b];
      end else if (extEn[b]) begin
        pinIn[b] = extVal[b];
      end else begin
        pinIn[b] = 1'b1;
      end
    end
  end
endmodule : ppcdr_pin_model

// file: tb/ppcdr_port_regs_tb_top.sv
// Purpose: self-checking bench for the port register block
// Assumes: read data one cycle after the read strobe, 50 MHz mclk
// Notes: pin levels come from the pin model
`timescale 1ns/1ns
module ppcdr_port_regs_tb_top import ppcdr_pkg::*;;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic [5:0] hostAddr = 6'h00;
  logic hostWr = 1'b0;
  logic hostRd = 1'b0;
  logic [7:0] hostWdata = 8'h00;
  logic [31:0] pldOe = 32'h0;
  logic [31:0] pldOutSel = 32'h0;
  logic [7:0] cellNextFirst = 8'h3C;
  logic [7:0] cellNextSecond = 8'hC3;
  logic firstToB = 1'b0;
  logic secondToC = 1'b0;
  logic [15:0] addrOutValue = 16'h0;
  logic [2:0] externalSelectTerm = 3'h0;
  logic [2:0] externalSelectPolarity = 3'h0;
  logic busModeA = 1'b0;
  logic busDriveA = 1'b0;
  logic [7:0] busDataA = 8'h00;
  logic [2:0] fourthPortDedicated = 3'h0;
  logic dbeMode = 1'b0;
  logic batteryMode = 1'b0;
  logic vccBelowBat = 1'b0;
  logic [31:0] extVal = 32'h0;
  logic [31:0] extEn = 32'h0;
  logic [7:0] hostRdata;
  logic [31:0] portPinIn, portPinOut, portPinOe_n, portSlewFast;
  logic [23:0] logicInputCells;
  logic [2:0] fourthPortArray;
  logic [7:0] outputCellGroupFirst, outputCellGroupSecond;
  logic dataByteEnableIn, batteryOnIndicator, ioSpaceDisabled;
  int errorCnt = 0;
  int compares = 0;

  always #10 mclk = ~mclk;

  ppcdr_port_regs dut (.mclk(mclk), .srst(srst), .hostAddr(hostAddr), .hostWr(hostWr),
    .hostRd(hostRd), .hostWdata(hostWdata), .hostRdata(hostRdata), .portPinIn(portPinIn),
    .portPinOut(portPinOut), .portPinOe_n(portPinOe_n), .portSlewFast(portSlewFast),
    .pldOe(pldOe), .pldOutSel(pldOutSel), .cellNextFirst(cellNextFirst),
    .cellNextSecond(cellNextSecond), .firstToB(firstToB), .secondToC(secondToC),
    .addrOutValue(addrOutValue), .externalSelectTerm(externalSelectTerm),
    .externalSelectPolarity(externalSelectPolarity), .busModeA(busModeA),
    .busDriveA(busDriveA), .busDataA(busDataA), .fourthPortDedicated(fourthPortDedicated),
    .dbeMode(dbeMode), .batteryMode(batteryMode), .vccBelowBat(vccBelowBat),
    .logicInputCells(logicInputCells), .fourthPortArray(fourthPortArray),
    .outputCellGroupFirst(outputCellGroupFirst),
    .outputCellGroupSecond(outputCellGroupSecond), .dataByteEnableIn(dataByteEnableIn),
    .batteryOnIndicator(batteryOnIndicator), .ioSpaceDisabled(ioSpaceDisabled));

  ppcdr_pin_model pins (.pinOut(portPinOut), .pinOe_n(portPinOe_n), .extVal(extVal),
    .extEn(extEn), .pinIn(portPinIn));

  // ------------------------------------------------------------
  // host access tasks
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      errorCnt++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : tick

  task automatic wr(input logic [1:0] p, input logic [3:0] i, input logic [7:0] d);
    tick(1);
    hostAddr = {p, i};
    hostWdata = d;
    hostWr = 1'b1;
    tick(1);
    hostWr = 1'b0;
  endtask : wr

  task automatic rd(input logic [1:0] p, input logic [3:0] i, input logic [7:0] exp);
    tick(1);
    hostAddr = {p, i};
    hostRd = 1'b1;
    tick(1);
    hostRd = 1'b0;
    chk($sformatf("reg %0d.%0h", p, i), hostRdata, exp);
  endtask : rd

  task automatic tallyAndFinish;
    if (errorCnt == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : tallyAndFinish

  initial begin
    repeat (20000) @(posedge mclk);
    errorCnt++;
    tallyAndFinish;
  end

  // ------------------------------------------------------------
  // test sequence
  // ------------------------------------------------------------
  initial begin
    tick(3);
    srst = 1'b0;
    for (int p = 0; p < 4; p++) begin
      rd(p[1:0], REG_DIR, 8'h00);
      rd(p[1:0], REG_DRIVE, 8'h00);
    end
    rd(PORT_A, REG_CTRL, 8'h00);
    rd(PORT_B, REG_CTRL, 8'h00);
    for (int p = 0; p < 3; p++) begin
      rd(p[1:0], REG_CELL_MASK, 8'h00);
    end
    chk("oe_n all", {7'h0, &portPinOe_n}, 8'h01);
    chk("slew all", {7'h0, |portSlewFast}, 8'h00);
    // direction from register or enable term
    wr(PORT_B, REG_DATA_OUT, 8'h5A);
    rd(PORT_B, REG_DATA_OUT, 8'h5A);
    wr(PORT_B, REG_DIR, 8'h0F);
    pldOe[12] = 1'b1;
    tick(4);
    rd(PORT_B, REG_ENABLE_OUT, 8'h1F);
    chk("oe_n B", portPinOe_n[15:8], 8'hE0);
    chk("out B", portPinOut[15:8] & 8'h1F, 8'h1A);
    rd(PORT_B, REG_DATA_IN, 8'hFA);
    wr(PORT_B, REG_DIR, 8'h00);
    pldOe[12] = 1'b0;
    tick(4);
    rd(PORT_B, REG_ENABLE_OUT, 8'h00);
    // drive type and slew
    wr(PORT_A, REG_DRIVE, 8'hFF);
    wr(PORT_A, REG_DIR, 8'hFF);
    wr(PORT_A, REG_DATA_OUT, 8'h5A);
    wr(PORT_C, REG_DRIVE, 8'hFF);
    wr(PORT_D, REG_DRIVE, 8'hFF);
    tick(4);
    chk("oe_n A", portPinOe_n[7:0], 8'h50);
    chk("slew A", portSlewFast[7:0], 8'h0F);
    chk("slew C", portSlewFast[23:16], 8'h00);
    chk("slew D", {5'h00, portSlewFast[26:24]}, 8'h07);
    rd(PORT_C, REG_DRIVE, 8'hFF);
    rd(PORT_D, REG_DRIVE, 8'h07);
    wr(PORT_A, REG_DRIVE, 8'h00);
    tick(4);
    chk("oe_n A", portPinOe_n[7:0], 8'h00);
    // registers absent on some ports
    for (int i = 4; i < 9; i++) begin
      wr(PORT_D, i[3:0], 8'hFF);
      rd(PORT_D, i[3:0], 8'h00);
    end
    wr(PORT_C, REG_CTRL, 8'hFF);
    rd(PORT_C, REG_CTRL, 8'h00);
    rd(PORT_A, 4'hF, 8'h00);
    // output cells, mask and cell clock
    chk("cells one", outputCellGroupFirst, 8'h3C);
    extEn[25] = 1'b1;
    fourthPortDedicated[1] = 1'b1;
    tick(4);
    wr(PORT_A, REG_CELL_OUT, 8'h1E);
    rd(PORT_A, REG_CELL_OUT, 8'h1E);
    wr(PORT_A, REG_CELL_MASK, 8'hF0);
    wr(PORT_A, REG_CELL_OUT, 8'hA5);
    rd(PORT_A, REG_CELL_MASK, 8'hF0);
    rd(PORT_A, REG_CELL_OUT, 8'h15);
    wr(PORT_A, REG_CELL_MASK, 8'hFF);
    wr(PORT_A, REG_CELL_OUT, 8'h00);
    rd(PORT_A, REG_CELL_OUT, 8'h15);
    cellNextFirst = 8'h81;
    firstToB = 1'b1;
    secondToC = 1'b1;
    extVal[25] = 1'b1;
    tick(5);
    rd(PORT_B, REG_CELL_OUT, 8'h81);
    rd(PORT_C, REG_CELL_OUT, 8'hC3);
    chk("cells two", outputCellGroupSecond, 8'hC3);
    fourthPortDedicated[1] = 1'b0;
    // input cells and direct array inputs
    wr(PORT_A, REG_DIR, 8'h00);
    extVal[7:0] = 8'hC6;
    extEn[7:0] = 8'hFF;
    extVal[26:24] = 3'b101;
    extEn[26:24] = 3'b111;
    tick(5);
    rd(PORT_A, REG_CELL_IN, 8'hC6);
    rd(PORT_A, REG_DATA_IN, 8'hC6);
    chk("imc A", logicInputCells[7:0], 8'hC6);
    chk("array D", {5'h00, fourthPortArray}, 8'h05);
    extEn = 32'h0;
    // external selects
    pldOutSel[26:24] = 3'b111;
    externalSelectTerm = 3'b101;
    externalSelectPolarity = 3'b011;
    wr(PORT_D, REG_DIR, 8'hFF);
    rd(PORT_D, REG_DIR, 8'h07);
    tick(3);
    chk("sel out", {5'h00, portPinOut[26:24]}, 8'h06);
    chk("sel oe_n", {5'h00, portPinOe_n[26:24]}, 8'h00);
    wr(PORT_D, REG_DIR, 8'h00);
    pldOe[24] = 1'b1;
    tick(4);
    chk("sel oe_n", {5'h00, portPinOe_n[26:24]}, 8'h06);
    pldOe = 32'h0;
    pldOutSel = 32'h0;
    // byte enable and battery indicator
    dbeMode = 1'b1;
    batteryMode = 1'b1;
    vccBelowBat = 1'b1;
    extEn[23] = 1'b1;
    extVal[23] = 1'b1;
    tick(5);
    chk("dbe", {7'h0, dataByteEnableIn}, 8'h01);
    chk("battery", {7'h0, batteryOnIndicator}, 8'h01);
    extVal[23] = 1'b0;
    vccBelowBat = 1'b0;
    tick(5);
    chk("dbe", {7'h0, dataByteEnableIn}, 8'h00);
    chk("battery", {7'h0, batteryOnIndicator}, 8'h00);
    // address out and host data bus
    addrOutValue = 16'h1234;
    wr(PORT_A, REG_CTRL, 8'hFF);
    wr(PORT_B, REG_CTRL, 8'hFF);
    wr(PORT_A, REG_DIR, 8'hFF);
    wr(PORT_B, REG_DIR, 8'hFF);
    rd(PORT_A, REG_CTRL, 8'hFF);
    tick(3);
    chk("addr A", portPinOut[7:0], 8'h34);
    chk("addr B", portPinOut[15:8], 8'h12);
    busModeA = 1'b1;
    busDriveA = 1'b1;
    busDataA = 8'h96;
    tick(4);
    chk("bus A", portPinOut[7:0], 8'h96);
    chk("bus oe_n", portPinOe_n[7:0], 8'h00);
    busModeA = 1'b0;
    // chip select blocks register space
    extEn[26] = 1'b1;
    extVal[26] = 1'b1;
    fourthPortDedicated[2] = 1'b1;
    tick(5);
    chk("cs off", {7'h0, ioSpaceDisabled}, 8'h01);
    wr(PORT_A, REG_DATA_OUT, 8'hFF);
    rd(PORT_A, REG_DATA_OUT, 8'h00);
    extVal[26] = 1'b0;
    tick(5);
    rd(PORT_A, REG_DATA_OUT, 8'h5A);
    tallyAndFinish;
  end
endmodule : ppcdr_port_regs_tb_top
